// ===== logic/dtse_engine.sv
// Transfer/search engine, with its byte FIFO
`timescale 1ns/1ns
module dtse_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
)(
    input  wire logic             i_ref_clk,
    input  wire logic             i_sys_rst,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic      [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wp_q;
    logic [AW-1:0]    rp_q;
    logic [AW:0]      cnt_q;
    logic             push;
    logic             pop;

    assign o_in_ready  = (cnt_q < (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_q != '0);
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;
    assign o_out_data  = mem_q[rp_q];

    always_ff @(posedge i_ref_clk)
    begin
        if (push)
            mem_q[wp_q] <= i_in_data;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            wp_q  <= '0;
            rp_q  <= '0;
            cnt_q <= '0;
        end
        else
        begin
            if (push)
                wp_q <= (wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1;
            if (pop)
                rp_q <= (rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1;
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // dtse_fifo

`timescale 1ns/1ns
module dtse_engine #(
    parameter int FIFO_DEPTH = 32
)(
    input  wire logic                       i_ref_clk,
    input  wire logic                       i_sys_rst,
    input  wire dtse_pkg::dtse_ctrl_type    i_ctrl,
    input  wire dtse_pkg::dtse_port_type    i_port_a,
    input  wire dtse_pkg::dtse_port_type    i_port_b,
    input  wire logic                       i_ctrl_wr,
    input  wire logic                       i_enable_cmd,
    input  wire logic                       i_load_cmd,
    input  wire logic                       i_clr_status,
    input  wire logic                       i_wide_bus,
    input  wire logic                       i_rdy_a,
    input  wire logic                       i_rdy_b,
    input  wire logic                       i_bus_grant_in,
    input  wire logic                       i_bus_request_line,
    input  wire logic                       i_int_ack,
    input  wire logic                       i_int_en_in,
    input  wire logic [15:0]                i_data,
    output logic                            o_bus_request_line_oe,
    output logic                            o_bus_grant_out,
    output logic                            o_bus_own,
    output logic [15:0]                     o_addr,
    output logic [15:0]                     o_data,
    output logic                            o_data_oe,
    output logic                            o_mem_req,
    output logic                            o_io_req,
    output logic                            o_rd,
    output logic                            o_wr,
    output logic                            o_int,
    output logic                            o_int_en_out,
    output logic [7:0]                      o_vector,
    output logic                            o_enabled,
    output logic                            o_ctrl_accepted,
    output dtse_pkg::dtse_stat_type         o_status
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0, ST_REQ = 3'h1, ST_RD = 3'h3, ST_WR = 3'h2, ST_DONE = 3'h6,
        ST_HOLD = 3'h7
    } dtse_state_type;

    dtse_state_type          st_q;
    dtse_pkg::dtse_ctrl_type ctl_q;
    dtse_pkg::dtse_port_type pa_q;
    dtse_pkg::dtse_port_type pb_q;
    dtse_pkg::dtse_stat_type sts_q;
    logic [15:0]  buf_a_q;
    logic [15:0]  buf_b_q;
    logic [15:0]  cnt_q;
    logic [1:0]   cyc_q;
    logic         en_q;
    logic         int_q;
    logic [2:0]   ra_q;
    logic [2:0]   rb_q;
    logic [2:0]   rq_q;
    logic [2:0]   gi_q;
    logic         rdy_a;
    logic         rdy_b;
    logic         other_req;
    logic         grant;
    logic         rdy_src;
    logic         is_match;
    logic         last;
    logic         do_write;
    logic         cyc_end;
    logic [1:0]   cyc_len;
    logic         f_in_rdy;
    logic         f_out_v;
    logic [7:0]   f_out_d;
    logic [15:0]  data_q;

    // Three stage sync, change accepted when stages two and three agree
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            ra_q <= 3'h0;
            rb_q <= 3'h0;
            rq_q <= 3'h0;
            gi_q <= 3'h0;
            rdy_a <= 1'b0;
            rdy_b <= 1'b0;
            other_req <= 1'b0;
            grant <= 1'b0;
        end
        else
        begin
            ra_q <= {ra_q[1:0], i_rdy_a};
            rb_q <= {rb_q[1:0], i_rdy_b};
            rq_q <= {rq_q[1:0], i_bus_request_line};
            gi_q <= {gi_q[1:0], i_bus_grant_in};
            if (ra_q[2] == ra_q[1]) rdy_a <= ra_q[2];
            if (rb_q[2] == rb_q[1]) rdy_b <= rb_q[2];
            if (rq_q[2] == rq_q[1]) other_req <= rq_q[2];
            if (gi_q[2] == gi_q[1]) grant <= gi_q[2];
        end
    end

    function automatic logic [15:0] step_addr(input logic [15:0] a,
                                             input dtse_pkg::dtse_step_type s);
        step_addr = (s == dtse_pkg::ADR_INC) ? a + dtse_pkg::ADDR_STEP :
                    (s == dtse_pkg::ADR_DEC) ? a - dtse_pkg::ADDR_STEP : a;
    endfunction

    assign rdy_src  = ctl_q.a_is_src ? rdy_a : rdy_b;
    assign is_match = f_out_v && (((f_out_d ^ ctl_q.match) & ~ctl_q.mask) == 8'h00);
    assign last     = (cnt_q == ctl_q.len_m1);
    assign do_write = (ctl_q.cls != dtse_pkg::CLS_SRCH);
    assign cyc_len  = (st_q == ST_RD) ? (ctl_q.a_is_src ? pa_q.rd_cyc : pb_q.rd_cyc)
                                      : (ctl_q.a_is_src ? pb_q.wr_cyc : pa_q.wr_cyc);
    assign cyc_end  = (cyc_q >= cyc_len) && (cyc_q >= dtse_pkg::CYC_MIN - 2'h1);

    dtse_fifo #(.WIDTH(dtse_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_ref_clk   (i_ref_clk),
        .i_sys_rst   (i_sys_rst),
        .i_in_valid  (st_q == ST_RD && cyc_end),
        .o_in_ready  (f_in_rdy),
        .i_in_data   (i_data[7:0]),
        .o_out_valid (f_out_v),
        .i_out_ready (st_q == ST_WR && cyc_end),
        .o_out_data  (f_out_d)
    );

    // Control interface; writes only while buses are not owned
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            ctl_q   <= '0;
            pa_q    <= '0;
            pb_q    <= '0;
            en_q    <= 1'b0;
            buf_a_q <= dtse_pkg::CNT_ZERO;
            buf_b_q <= dtse_pkg::CNT_ZERO;
        end
        else if (st_q == ST_IDLE || st_q == ST_DONE)
        begin
            if (i_ctrl_wr)
            begin
                ctl_q <= i_ctrl;
                pa_q  <= i_port_a;
                pb_q  <= i_port_b;
                en_q  <= 1'b0;
            end
            else if (i_enable_cmd)
                en_q <= 1'b1;
            if (i_load_cmd)
            begin
                buf_a_q <= i_port_a.start;
                buf_b_q <= i_port_b.start;
            end
        end
        else if (st_q == ST_WR && cyc_end && last && !ctl_q.auto_restart)
            en_q <= 1'b0;
        else if (st_q == ST_WR && cyc_end && is_match && ctl_q.stop_on_match
                 && ctl_q.cls != dtse_pkg::CLS_XFER)
            en_q <= 1'b0;
    end
    assign o_ctrl_accepted = i_ctrl_wr && (st_q == ST_IDLE || st_q == ST_DONE);

    // Bus tenure sequencer
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            st_q  <= ST_IDLE;
            cyc_q <= 2'h0;
            cnt_q <= dtse_pkg::CNT_ZERO;
            data_q <= 16'h0000;
            sts_q <= '0;
        end
        else
        begin
            if (i_clr_status)
            begin
                sts_q.rdy_seen <= 1'b0;
                sts_q.matched  <= 1'b0;
                sts_q.eob      <= 1'b0;
            end
            sts_q.count  <= cnt_q;
            cyc_q <= (cyc_end || st_q == ST_IDLE || st_q == ST_REQ || st_q == ST_HOLD)
                     ? 2'h0 : cyc_q + 2'h1;
            case (st_q)
                ST_IDLE:
                begin
                    if (i_load_cmd)
                    begin
                        sts_q.addr_a <= i_port_a.start;
                        sts_q.addr_b <= i_port_b.start;
                        cnt_q <= dtse_pkg::CNT_ZERO;
                    end
                    if (en_q && rdy_src && !other_req)
                    begin
                        st_q <= ST_REQ;
                        sts_q.rdy_seen <= 1'b1;
                    end
                end
                ST_REQ:
                    if (grant)
                        st_q <= ST_RD;
                ST_RD:
                    if (cyc_end && f_in_rdy)
                    begin
                        data_q <= i_wide_bus ? i_data : {8'h00, i_data[7:0]};
                        st_q <= ST_WR;
                    end
                ST_WR:
                    if (cyc_end)
                    begin
                        if (is_match && ctl_q.cls != dtse_pkg::CLS_XFER)
                            sts_q.matched <= 1'b1;
                        sts_q.addr_a <= step_addr(sts_q.addr_a, pa_q.step);
                        sts_q.addr_b <= step_addr(sts_q.addr_b, pb_q.step);
                        cnt_q <= cnt_q + 16'h0001;
                        if (last)
                        begin
                            sts_q.eob <= 1'b1;
                            cnt_q <= dtse_pkg::CNT_ZERO;
                            if (ctl_q.auto_restart)
                            begin
                                sts_q.addr_a <= buf_a_q;
                                sts_q.addr_b <= buf_b_q;
                            end
                            st_q <= ST_DONE;
                        end
                        else if (is_match && ctl_q.stop_on_match && ctl_q.cls != dtse_pkg::CLS_XFER)
                            st_q <= ST_DONE;
                        else if (ctl_q.mode == dtse_pkg::MOD_BYTE)
                            st_q <= ST_DONE;
                        else if (ctl_q.mode == dtse_pkg::MOD_BURST && !rdy_src)
                            st_q <= ST_DONE;
                        else if (rdy_src)
                            st_q <= ST_RD;
                        else
                            st_q <= ST_HOLD;
                    end
                ST_HOLD:
                    if (rdy_src)
                        st_q <= ST_RD;
                ST_DONE:
                    st_q <= ST_IDLE;
                default:
                    st_q <= ST_IDLE;
            endcase
        end
    end

    // Interrupt daisy chain with vector modification
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            int_q <= 1'b0;
        else if (st_q == ST_WR && cyc_end &&
                 ((ctl_q.ie_eob && last) ||
                  (ctl_q.ie_match && is_match && ctl_q.cls != dtse_pkg::CLS_XFER)))
            int_q <= 1'b1;
        else if (st_q == ST_IDLE && en_q && rdy_src && ctl_q.ie_rdy)
            int_q <= 1'b1;
        else if (i_int_ack)
            int_q <= 1'b0;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            o_vector <= dtse_pkg::VEC_RST;
        else if (!ctl_q.vec_mod)
            o_vector <= ctl_q.vector;
        else
            o_vector <= {ctl_q.vector[7:3],
                         sts_q.matched && sts_q.eob ? dtse_pkg::VEC_BOTH :
                         sts_q.eob ? dtse_pkg::VEC_EOB :
                         sts_q.matched ? dtse_pkg::VEC_MATCH : dtse_pkg::VEC_RDY,
                         ctl_q.vector[0]};
    end

    assign o_int        = int_q && i_int_en_in;
    assign o_int_en_out = i_int_en_in && !int_q;
    assign o_status     = '{rdy_seen: sts_q.rdy_seen, matched: sts_q.matched, eob: sts_q.eob,
                            int_pend: int_q, count: sts_q.count, addr_a: sts_q.addr_a,
                            addr_b: sts_q.addr_b};
    assign o_enabled    = en_q;

    // Bus outputs; address, strobes and data enable active only while buses are owned, request and grant out are not
    assign o_bus_own             = grant && o_bus_request_line_oe && st_q != ST_REQ;
    assign o_bus_request_line_oe = (st_q != ST_IDLE && st_q != ST_DONE);
    assign o_bus_grant_out       = grant && !o_bus_request_line_oe;
    assign o_addr    = !o_bus_own ? 16'h0000 :
                       ((st_q == ST_RD) == ctl_q.a_is_src) ? sts_q.addr_a : sts_q.addr_b;
    assign o_data    = data_q;
    assign o_data_oe = o_bus_own && st_q == ST_WR && do_write;
    assign o_rd      = o_bus_own && st_q == ST_RD;
    assign o_wr      = o_data_oe;
    assign o_io_req  = o_bus_own && ((st_q == ST_RD) == ctl_q.a_is_src ? pa_q.is_io : pb_q.is_io);
    assign o_mem_req = o_bus_own && !o_io_req;
endmodule // dtse_engine

// ===== pkg/dtse_pkg.sv
// Constants and types for the dual port transfer/search engine
package dtse_pkg;
    localparam int          ADDR_W       = 16;
    localparam int          DATA_W       = 8;
    localparam int          CYC_W        = 2;
    localparam logic [1:0]  CYC_MIN      = 2'h2;
    localparam logic [15:0] CNT_ZERO     = 16'h0000;
    localparam logic [15:0] ADDR_STEP    = 16'h0001;
    localparam logic [7:0]  VEC_RST      = 8'h00;
    localparam logic [1:0]  VEC_MATCH    = 2'h1;
    localparam logic [1:0]  VEC_EOB      = 2'h2;
    localparam logic [1:0]  VEC_BOTH     = 2'h3;
    localparam logic [1:0]  VEC_RDY      = 2'h0;

    typedef enum logic [1:0] {CLS_XFER = 2'h1, CLS_SRCH = 2'h2, CLS_BOTH = 2'h3} dtse_class_type;
    typedef enum logic [1:0] {MOD_BYTE = 2'h0, MOD_BURST = 2'h1, MOD_CONT = 2'h2} dtse_mode_type;
    typedef enum logic [1:0] {ADR_FIX = 2'h0, ADR_INC = 2'h1, ADR_DEC = 2'h2} dtse_step_type;

    // Per port configuration
    typedef struct packed {
        logic              is_io;
        dtse_step_type     step;
        logic [CYC_W-1:0]  rd_cyc;
        logic [CYC_W-1:0]  wr_cyc;
        logic [ADDR_W-1:0] start;
    } dtse_port_type;

    // Whole control word, written while idle
    typedef struct packed {
        dtse_class_type    cls;
        dtse_mode_type     mode;
        logic              a_is_src;
        logic [15:0]       len_m1;
        logic [7:0]        match;
        logic [7:0]        mask;
        logic              stop_on_match;
        logic              auto_restart;
        logic              ie_rdy;
        logic              ie_match;
        logic              ie_eob;
        logic              vec_mod;
        logic [7:0]        vector;
    } dtse_ctrl_type;

    // Status seen by the processor
    typedef struct packed {
        logic        rdy_seen;
        logic        matched;
        logic        eob;
        logic        int_pend;
        logic [15:0] count;
        logic [15:0] addr_a;
        logic [15:0] addr_b;
    } dtse_stat_type;
endpackage

// ===== tb/dtse_engine_props.sv
// Checker for the engine's bus and control port behaviour
`timescale 1ns/1ns
module dtse_engine_props #(
    parameter int FIFO_DEPTH = 32
)(
    input wire logic        i_ref_clk,
    input wire logic        i_sys_rst,
    input wire logic        i_ctrl_wr,
    input wire logic        i_bus_grant_in,
    input wire logic        o_bus_request_line_oe,
    input wire logic        o_bus_grant_out,
    input wire logic        o_bus_own,
    input wire logic [15:0] o_addr,
    input wire logic        o_data_oe,
    input wire logic        o_mem_req,
    input wire logic        o_io_req,
    input wire logic        o_rd,
    input wire logic        o_wr,
    input wire logic        o_enabled,
    input wire logic        o_ctrl_accepted
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_rd_start;
        $rose(o_rd) ##0 o_bus_own;
    endsequence
    sequence s_rd_hold;
        o_rd [*2];
    endsequence

    chk_addr_idle: assert property (!o_bus_own |-> o_addr == 16'h0000)
        else $error("Address driven without bus ownership");
    chk_own_grant: assert property ($rose(o_bus_own) |-> i_bus_grant_in && $past(i_bus_grant_in, 2))
        else $error("Buses taken before grant");
    chk_own_req: assert property (o_bus_own |-> o_bus_request_line_oe)
        else $error("Buses owned without request");
    chk_strobe_excl: assert property (!(o_rd && o_wr))
        else $error("Read and write strobes together");
    chk_strobe_own: assert property ((o_rd || o_wr) |-> o_bus_own)
        else $error("Strobe outside tenure");
    chk_wr_drive: assert property (o_wr |-> o_data_oe)
        else $error("Write without data drive");
    chk_space_one: assert property ((o_rd || o_wr) |-> (o_mem_req ^ o_io_req))
        else $error("Not exactly one address space selected");
    chk_rd_min: assert property (s_rd_start |-> s_rd_hold)
        else $error("Read strobe shorter than two cycles");
    chk_ctrl_refuse: assert property (i_ctrl_wr && o_bus_own |-> !o_ctrl_accepted)
        else $error("Control write taken while owning buses");
    chk_ctrl_disable: assert property (o_ctrl_accepted |=> !o_enabled)
        else $error("Engine still enabled after control write");
    chk_grant_hold: assert property (o_bus_request_line_oe |-> !o_bus_grant_out)
        else $error("Grant passed on while requesting");
endmodule // dtse_engine_props

bind dtse_engine dtse_engine_props #(.FIFO_DEPTH(FIFO_DEPTH)) dtse_engine_props_i (
    .i_ref_clk, .i_sys_rst, .i_ctrl_wr, .i_bus_grant_in, .o_bus_request_line_oe,
    .o_bus_grant_out, .o_bus_own, .o_addr, .o_data_oe, .o_mem_req, .o_io_req,
    .o_rd, .o_wr, .o_enabled, .o_ctrl_accepted);

// ===== tb/dtse_host_model.sv
// Host side model: bus grant and byte-wide memory and peripheral space
`timescale 1ns/1ns
module dtse_host_model #(
    parameter int GRANT_DLY = 3
)(
    input  wire logic        i_ref_clk,
    input  wire logic        i_req,
    input  wire logic        i_own,
    input  wire logic [15:0] i_addr,
    input  wire logic        i_rd,
    input  wire logic        i_wr,
    input  wire logic [15:0] i_wdata,
    output logic             o_grant,
    output logic [15:0]      o_rdata
);
    logic [7:0]  mem [256];
    int          wr_count = 0;
    int          tenures  = 0;
    int          dly      = 0;
    logic [15:0] last_q   = 16'h0000;
    logic [15:0] wa_q     = 16'h0000;
    logic [15:0] wd_q     = 16'h0000;
    logic        wr_q     = 1'b0;
    logic        own_q    = 1'b0;

    initial o_grant = 1'b0;
    // Grant only after a delay, withdrawn once request drops
    always @(posedge i_ref_clk)
    begin
        dly = i_req ? dly + 1 : 0;
        #1 o_grant = i_req && (dly > GRANT_DLY);
    end
    // Released data lines show a changing pattern
    always_comb o_rdata = i_rd ? {8'h00, mem[i_addr[7:0]]} : ~last_q;
    always @(posedge i_ref_clk)
    begin
        last_q <= o_rdata;
        wr_q   <= i_wr;
        wa_q   <= i_addr;
        wd_q   <= i_wdata;
        own_q  <= i_own;
        if (wr_q && !i_wr)
        begin
            mem[wa_q[7:0]] <= wd_q[7:0];
            wr_count++;
        end
        if (i_own && !own_q)
            tenures++;
    end
endmodule // dtse_host_model

// ===== tb/test_dtse_engine.sv
// Self-checking bench for the transfer/search engine
`timescale 1ns/1ns
module test_dtse_engine;
    logic                    i_ref_clk, i_sys_rst, i_ctrl_wr, i_enable_cmd, i_load_cmd;
    logic                    i_clr_status, i_wide_bus, i_rdy_a, i_rdy_b, i_bus_grant_in;
    logic                    i_bus_request_line, i_int_ack, i_int_en_in;
    logic [15:0]             i_data, o_addr, o_data;
    logic                    o_bus_request_line_oe, o_bus_grant_out, o_bus_own, o_data_oe;
    logic                    o_mem_req, o_io_req, o_rd, o_wr, o_int, o_int_en_out;
    logic                    o_enabled, o_ctrl_accepted;
    logic [7:0]              o_vector;
    dtse_pkg::dtse_ctrl_type i_ctrl;
    dtse_pkg::dtse_port_type i_port_a, i_port_b;
    dtse_pkg::dtse_stat_type o_status;
    int                      bad_count = 0;
    int                      tests_run = 0;

    assign i_bus_request_line = o_bus_request_line_oe;
    dtse_engine #(.FIFO_DEPTH(32)) dtse_engine_i (.i_ref_clk, .i_sys_rst, .i_ctrl, .i_port_a,
        .i_port_b, .i_ctrl_wr, .i_enable_cmd, .i_load_cmd, .i_clr_status, .i_wide_bus,
        .i_rdy_a, .i_rdy_b, .i_bus_grant_in, .i_bus_request_line, .i_int_ack, .i_int_en_in,
        .i_data, .o_bus_request_line_oe, .o_bus_grant_out, .o_bus_own, .o_addr, .o_data,
        .o_data_oe, .o_mem_req, .o_io_req, .o_rd, .o_wr, .o_int, .o_int_en_out, .o_vector,
        .o_enabled, .o_ctrl_accepted, .o_status);
    dtse_host_model dtse_host_model_i (.i_ref_clk, .i_req(o_bus_request_line_oe),
        .i_own(o_bus_own), .i_addr(o_addr), .i_rd(o_rd), .i_wr(o_wr), .i_wdata(o_data),
        .o_grant(i_bus_grant_in), .o_rdata(i_data));

    initial
    begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic step(int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    task automatic cmp_bit(logic got, logic exp, string what);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: %s", $time, what);
        end
    endtask
    task automatic cmp_val(logic [15:0] got, logic [15:0] exp, string what);
        tests_run++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR at %0t: %s got %h", $time, what, got);
        end
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    function automatic logic [7:0] src_byte(int k);
        return 8'(16 + k) ^ 8'h5a;
    endfunction
    // Four bytes from memory 0x10 up to peripheral 0x83 down
    task automatic prog(dtse_pkg::dtse_class_type c, dtse_pkg::dtse_mode_type m,
                        logic [7:0] mask);
        for (int i = 0; i < 256; i++)
            dtse_host_model_i.mem[i] = 8'(i) ^ 8'h5a;
        i_ctrl = '{cls:c, mode:m, a_is_src:1'b1, len_m1:16'h0003, match:8'h08, mask:mask,
                   default:'0};
        i_port_a = '{is_io:1'b0, step:dtse_pkg::ADR_INC, rd_cyc:2'h2, wr_cyc:2'h2,
                     start:16'h0010};
        i_port_b = '{is_io:1'b1, step:dtse_pkg::ADR_DEC, rd_cyc:2'h3, wr_cyc:2'h3,
                     start:16'h0083};
        i_ctrl_wr = 1'b1;
        #1 cmp_bit(o_ctrl_accepted, 1'b1, "idle control write refused");
        step(1);
        i_ctrl_wr = 1'b0;
        i_load_cmd = 1'b1;
        step(1);
        i_load_cmd = 1'b0;
        i_clr_status = 1'b1;
        cmp_bit(o_enabled, 1'b0, "enabled before enable command");
        step(1);
        i_clr_status = 1'b0;
        i_enable_cmd = 1'b1;
        step(1);
        i_enable_cmd = 1'b0;
    endtask
    task automatic wait_done();
        for (int i = 0; i < 3000; i++)
        begin
            if (o_status.eob === 1'b1 && o_bus_own === 1'b0)
            begin
                step(2);
                return;
            end
            step(1);
        end
        bad_count++;
        $display("ERROR at %0t: block never completed", $time);
        summarize();
    endtask
    task automatic wait_own();
        for (int i = 0; i < 400 && o_bus_own !== 1'b1; i++)
            step(1);
        if (o_bus_own !== 1'b1)
        begin
            bad_count++;
            $display("ERROR at %0t: buses never taken", $time);
            summarize();
        end
    endtask
    task automatic check_dst();
        for (int k = 0; k < 4; k++)
            cmp_val(16'(dtse_host_model_i.mem[8'h83 - k]), 16'(src_byte(k)), "dest byte");
    endtask

    task automatic t_cont();
        int t0 = dtse_host_model_i.tenures;
        prog(dtse_pkg::CLS_XFER, dtse_pkg::MOD_CONT, 8'h00);
        wait_own();
        i_rdy_a = 1'b0;
        i_ctrl_wr = 1'b1;
        #1 cmp_bit(o_ctrl_accepted, 1'b0, "control write taken while owning");
        step(1);
        i_ctrl_wr = 1'b0;
        step(20);
        cmp_bit(o_bus_own, 1'b1, "buses released during pause");
        i_rdy_a = 1'b1;
        wait_done();
        cmp_val(16'(dtse_host_model_i.tenures - t0), 16'h0001, "tenure count");
        check_dst();
        cmp_val(o_status.addr_a, 16'h0014, "port A address");
        cmp_val(o_status.addr_b, 16'h007f, "port B address");
        $display("Test continuous transfer done");
    endtask
    task automatic t_byte();
        int t0 = dtse_host_model_i.tenures;
        prog(dtse_pkg::CLS_XFER, dtse_pkg::MOD_BYTE, 8'h00);
        wait_done();
        cmp_val(16'(dtse_host_model_i.tenures - t0), 16'h0004, "tenure count");
        check_dst();
        $display("Test byte mode done");
    endtask
    task automatic t_burst();
        prog(dtse_pkg::CLS_XFER, dtse_pkg::MOD_BURST, 8'h00);
        wait_own();
        i_rdy_a = 1'b0;
        step(30);
        cmp_bit(o_bus_own, 1'b0, "buses kept after ready dropped");
        cmp_bit(o_status.eob, 1'b0, "block ended early");
        i_rdy_a = 1'b1;
        wait_done();
        check_dst();
        $display("Test burst mode done");
    endtask
    // Masked match hits 0x48; unmasked finds nothing
    task automatic t_search();
        dtse_pkg::dtse_class_type cls [2] = '{dtse_pkg::CLS_SRCH, dtse_pkg::CLS_BOTH};
        logic [7:0]               msk [2] = '{8'hf0, 8'h00};
        int                       w0;
        for (int j = 0; j < 2; j++)
        begin
            w0 = dtse_host_model_i.wr_count;
            prog(cls[j], dtse_pkg::MOD_CONT, msk[j]);
            wait_done();
            cmp_bit(o_status.matched, j == 0, "match status");
            cmp_val(16'(dtse_host_model_i.wr_count - w0), j == 0 ? 16'h0000 : 16'h0004,
                    "write count");
        end
        $display("Test search done");
    endtask

    initial
    begin
        {i_sys_rst, i_rdy_a, i_rdy_b, i_int_en_in} = 4'hf;
        {i_ctrl_wr, i_enable_cmd, i_load_cmd, i_clr_status, i_wide_bus, i_int_ack} = 6'h00;
        i_ctrl = '0;
        i_port_a = '0;
        i_port_b = '0;
        step(16);
        i_sys_rst = 1'b0;
        step(1);
        cmp_bit(o_bus_request_line_oe, 1'b0, "request after reset");
        cmp_bit(o_bus_own, 1'b0, "buses owned after reset");
        t_cont();
        t_byte();
        t_burst();
        t_search();
        summarize();
    end
endmodule // test_dtse_engine
